// *** include/amfc_cfg.svh ***
// Constants for the accelerometer mode and filter control block.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef AMFC_CFG_SVH
`define AMFC_CFG_SVH
// =====================================================================
// Timebase
`define AMFC_CLK_HZ          10000000
`define AMFC_TICK_DIV        10000
`define AMFC_TICK_HZ         (`AMFC_CLK_HZ / `AMFC_TICK_DIV)
// =====================================================================
// Settling times in microseconds and in ticks
`define AMFC_SETTLE_LONG_US  462500
`define AMFC_SETTLE_SHORT_US 20000
`define AMFC_SETTLE_LONG_TK  ((`AMFC_SETTLE_LONG_US * (`AMFC_TICK_HZ / 1000) + 999) / 1000)
`define AMFC_SETTLE_SHORT_TK ((`AMFC_SETTLE_SHORT_US * (`AMFC_TICK_HZ / 1000) + 999) / 1000)
// =====================================================================
// Wake timer durations in ms (8 choices)
`define AMFC_WAKE_MS0        65
`define AMFC_WAKE_MS1        130
`define AMFC_WAKE_MS2        260
`define AMFC_WAKE_MS3        640
`define AMFC_WAKE_MS4        2560
`define AMFC_WAKE_MS5        5120
`define AMFC_WAKE_MS6        10240
`define AMFC_WAKE_MS7        30720
// =====================================================================
// Reset values, rate limit and timer width
`define AMFC_RST_RATE        3'h0
`define AMFC_RST_BW          3'h0
`define AMFC_RATE_MAX        3'h4
`define AMFC_TICK_W          20
`endif

// *** include/amfc_pkg.sv ***
// Types for the accelerometer mode and filter control block.
// Assumes amfc_cfg.svh holds the numeric constants.
`default_nettype none
package amfc_pkg;
    // Requested operating mode
    typedef enum logic [1:0] {
        AMFC_REQ_STANDBY = 2'b00,
        AMFC_REQ_WAKE    = 2'b01,
        AMFC_REQ_INSTANT = 2'b10,
        AMFC_REQ_MEASURE = 2'b11
    } amfc_req_type;
    // Internal state
    typedef enum logic [2:0] {
        AMFC_ST_STANDBY = 3'b000,
        AMFC_ST_SETTLE  = 3'b001,
        AMFC_ST_MEASURE = 3'b010,
        AMFC_ST_INSTANT = 3'b011,
        AMFC_ST_WSLEEP  = 3'b100,
        AMFC_ST_WON     = 3'b101
    } amfc_state_type;
endpackage
`default_nettype wire

// *** verilog/amfc_tick_div.sv ***
// Divider making a one-cycle tick enable from the system clock.
// Assumes one clock, asynchronous active-high reset.
`default_nettype none
`include "amfc_cfg.svh"
module amfc_tick_div #(
    // Cycles per tick; a smaller value compresses time in short runs
    parameter int unsigned DIV = `AMFC_TICK_DIV
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Tick out
    output logic      tick
);
    logic [13:0] cnt_reg;
    // =================================================================
    // Free-running divider; tick is a registered pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 14'h0000;
            tick    <= 1'b0;
        end else begin
            tick <= (cnt_reg == 14'(DIV - 1));
            if (cnt_reg == 14'(DIV - 1)) begin
                cnt_reg <= 14'h0000;
            end else begin
                cnt_reg <= cnt_reg + 14'h0001;
            end
        end
    end
endmodule // amfc_tick_div
`default_nettype wire

// *** verilog/amfc_down_timer.sv ***
// Loadable down counter stepped by the tick enable.
// Assumes load and tick come from the same clock domain.
`default_nettype none
`include "amfc_cfg.svh"
module amfc_down_timer (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Control
    input  wire logic                    load,
    input  wire logic [`AMFC_TICK_W-1:0] load_val,
    input  wire logic                    tick,
    // Status
    output logic                         done
);
    logic [`AMFC_TICK_W-1:0] cnt_reg;
    // =================================================================
    // Load wins over counting; done is a level once zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (load) begin
            cnt_reg <= load_val;
        end else if (tick && cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end
    assign done = (cnt_reg == '0) && !load;
endmodule // amfc_down_timer
`default_nettype wire

// *** verilog/amfc_mode_ctrl.sv ***
// Mode sequencer and sample-path control for the accelerometer.
// Assumes host configuration arrives as synchronous ports; the serial
// link, FIFO storage and activity detection live outside this block.
`default_nettype none
`include "amfc_cfg.svh"
module amfc_mode_ctrl #(
    parameter int unsigned TICK_DIV = `AMFC_TICK_DIV  // Clock cycles per 1 ms tick
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Configuration from power_control_reg and timing
    input  wire logic [1:0] mode_request,
    input  wire logic       settle_time_select,
    input  wire logic [2:0] wake_timer_select,
    input  wire logic [2:0] output_sample_rate,
    input  wire logic [2:0] aa_bw_select,
    input  wire logic [1:0] hpf_corner_select,
    input  wire logic       hpf_enable,
    input  wire logic       lpf_enable,
    input  wire logic       low_noise_select,
    input  wire logic       impact_high_range,
    input  wire logic       wake_auto_measure,
    input  wire logic       loop_mode,
    // Events from the sensing front end and the host link
    input  wire logic       impact_detected,
    input  wire logic       activity_detected,
    input  wire logic       sample_strobe,
    input  wire logic       host_burst_active,
    input  wire logic       fifo_read_byte,
    // Mode status
    output logic [2:0]      mode_state,
    output logic            mode_changed,
    output logic            sensing_on,
    // Sample path gating
    output logic            data_valid,
    output logic            fifo_store_en,
    output logic            irq_enable,
    output logic            irq_clear,
    output logic            fifo_advance,
    output logic            reg_addr_incr,
    // Filter settings in use
    output logic [2:0]      rate_eff,
    output logic [2:0]      aa_bw_eff,
    output logic [1:0]      hpf_corner_eff,
    output logic            hpf_on,
    output logic            lpf_on,
    output logic            low_noise_on,
    output logic            impact_thresh_high,
    output logic            wake_downstream
);
    // =================================================================
    // Declarations
    amfc_pkg::amfc_state_type state_reg;
    amfc_pkg::amfc_state_type state_next;
    logic                     tick;
    logic                     settle_load;
    logic                     settle_done;
    logic                     wake_load;
    logic                     wake_done;
    logic [`AMFC_TICK_W-1:0]  settle_ticks;
    logic [`AMFC_TICK_W-1:0]  wake_ticks;
    logic [2:0]               rate_reg;
    logic [2:0]               bw_reg;
    logic [2:0]               bw_limit;
    logic                     wake_ds_reg;
    logic                     active_entry;
    amfc_pkg::amfc_req_type   req;
    amfc_pkg::amfc_state_type prev_reg;

    localparam int unsigned TPM = `AMFC_TICK_HZ / 1000;  // ticks per ms

    assign req = amfc_pkg::amfc_req_type'(mode_request);

    // =================================================================
    // Timebase and timers
    amfc_tick_div #(.DIV(TICK_DIV)) u_tick (
        .clk  (clk),
        .rst  (rst),
        .tick (tick)
    );

    amfc_down_timer u_settle (
        .clk      (clk),
        .rst      (rst),
        .load     (settle_load),
        .load_val (settle_ticks),
        .tick     (tick),
        .done     (settle_done)
    );

    amfc_down_timer u_wake (
        .clk      (clk),
        .rst      (rst),
        .load     (wake_load),
        .load_val (wake_ticks),
        .tick     (tick),
        .done     (wake_done)
    );

    // Settling length picked by the select bit, long by default
    assign settle_ticks = settle_time_select ?
        `AMFC_TICK_W'(`AMFC_SETTLE_SHORT_TK) : `AMFC_TICK_W'(`AMFC_SETTLE_LONG_TK);

    // Wake interval lookup in ticks
    always_comb begin
        unique case (wake_timer_select)
            3'h0: wake_ticks = `AMFC_TICK_W'(`AMFC_WAKE_MS0 * TPM);
            3'h1: wake_ticks = `AMFC_TICK_W'(`AMFC_WAKE_MS1 * TPM);
            3'h2: wake_ticks = `AMFC_TICK_W'(`AMFC_WAKE_MS2 * TPM);
            3'h3: wake_ticks = `AMFC_TICK_W'(`AMFC_WAKE_MS3 * TPM);
            3'h4: wake_ticks = `AMFC_TICK_W'(`AMFC_WAKE_MS4 * TPM);
            3'h5: wake_ticks = `AMFC_TICK_W'(`AMFC_WAKE_MS5 * TPM);
            3'h6: wake_ticks = `AMFC_TICK_W'(`AMFC_WAKE_MS6 * TPM);
            3'h7: wake_ticks = `AMFC_TICK_W'(`AMFC_WAKE_MS7 * TPM);
        endcase
    end

    // =================================================================
    // Mode sequencer
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            amfc_pkg::AMFC_ST_STANDBY: begin
                if (req == amfc_pkg::AMFC_REQ_MEASURE) begin
                    state_next = amfc_pkg::AMFC_ST_SETTLE;
                end else if (req == amfc_pkg::AMFC_REQ_INSTANT) begin
                    state_next = amfc_pkg::AMFC_ST_INSTANT;
                end else if (req == amfc_pkg::AMFC_REQ_WAKE) begin
                    state_next = amfc_pkg::AMFC_ST_WSLEEP;
                end
            end
            amfc_pkg::AMFC_ST_SETTLE: begin
                if (settle_done) begin
                    state_next = amfc_pkg::AMFC_ST_MEASURE;
                end
            end
            amfc_pkg::AMFC_ST_MEASURE: begin
                state_next = amfc_pkg::AMFC_ST_MEASURE;
            end
            amfc_pkg::AMFC_ST_INSTANT: begin
                if (impact_detected) begin
                    state_next = amfc_pkg::AMFC_ST_SETTLE;
                end
            end
            amfc_pkg::AMFC_ST_WSLEEP: begin
                if (wake_done) begin
                    state_next = amfc_pkg::AMFC_ST_WON;
                end
            end
            amfc_pkg::AMFC_ST_WON: begin
                if (activity_detected && wake_auto_measure) begin
                    state_next = amfc_pkg::AMFC_ST_SETTLE;
                end else if (settle_done) begin
                    state_next = amfc_pkg::AMFC_ST_WSLEEP;
                end
            end
            default: state_next = amfc_pkg::AMFC_ST_STANDBY;
        endcase
        // Standby request overrides every mode; other modes change only via
        // standby or own events, so the host re-arms wake itself
        if (req == amfc_pkg::AMFC_REQ_STANDBY) begin
            state_next = amfc_pkg::AMFC_ST_STANDBY;
        end
    end

    // Restart settling on every active-phase entry
    assign active_entry = (state_next != state_reg) &&
                          (state_next == amfc_pkg::AMFC_ST_SETTLE ||
                           state_next == amfc_pkg::AMFC_ST_WON);
    assign settle_load = active_entry;
    assign wake_load   = (state_next != state_reg) &&
                         (state_next == amfc_pkg::AMFC_ST_WSLEEP);

    // State register; power-up lands in standby
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= amfc_pkg::AMFC_ST_STANDBY;
            prev_reg  <= amfc_pkg::AMFC_ST_STANDBY;
        end else begin
            state_reg <= state_next;
            prev_reg  <= state_reg;
        end
    end

    // Wake downstream flag: set on wake activity, dropped in standby
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_ds_reg <= 1'b0;
        end else if (state_reg == amfc_pkg::AMFC_ST_WON && activity_detected) begin
            wake_ds_reg <= 1'b1;
        end else if (state_reg == amfc_pkg::AMFC_ST_STANDBY) begin
            wake_ds_reg <= 1'b0;
        end
    end

    // =================================================================
    // Rate and bandwidth, loaded only in standby so a live change
    // cannot glitch the sample path mid-measurement
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rate_reg <= `AMFC_RST_RATE;
            bw_reg   <= `AMFC_RST_BW;
        end else if (state_reg == amfc_pkg::AMFC_ST_STANDBY) begin
            rate_reg <= (output_sample_rate > `AMFC_RATE_MAX) ?
                        `AMFC_RATE_MAX : output_sample_rate;
            bw_reg   <= aa_bw_select;
        end
    end

    // Code n is 160 Hz * 2^n; half the rate 320*2^r is code r
    assign bw_limit  = rate_reg;
    assign aa_bw_eff = (bw_reg > bw_limit) ? bw_limit : bw_reg;
    assign rate_eff  = rate_reg;

    // Corner code passes through; it scales with rate in the filter
    assign hpf_corner_eff     = hpf_corner_select;
    assign hpf_on             = hpf_enable;
    assign lpf_on             = lpf_enable;
    assign low_noise_on       = low_noise_select;
    assign impact_thresh_high = impact_high_range;

    // =================================================================
    // Status and gating
    assign mode_state   = state_reg;
    assign mode_changed = (state_reg != prev_reg);
    assign sensing_on   = (state_reg != amfc_pkg::AMFC_ST_STANDBY) &&
                          (state_reg != amfc_pkg::AMFC_ST_WSLEEP);
    // Data in measure after settling and in wake-on; wake-on samples come at the same strobe rate as measure
    assign data_valid    = sample_strobe &&
                           (state_reg == amfc_pkg::AMFC_ST_MEASURE ||
                            state_reg == amfc_pkg::AMFC_ST_WON);
    assign fifo_store_en = sample_strobe && state_reg == amfc_pkg::AMFC_ST_MEASURE;
    assign irq_enable    = (state_reg == amfc_pkg::AMFC_ST_MEASURE) ||
                           (state_reg == amfc_pkg::AMFC_ST_SETTLE);
    // Standby clears pending interrupts; loop mode self-clears
    assign irq_clear     = (state_reg == amfc_pkg::AMFC_ST_STANDBY) ||
                           (loop_mode && activity_detected);
    // Each FIFO byte read moves on with no length limit
    assign fifo_advance  = fifo_read_byte;
    assign reg_addr_incr = host_burst_active;
    assign wake_downstream = wake_ds_reg;

    // =================================================================
    // Checks
    sequence s_enter_settle;
        state_reg != amfc_pkg::AMFC_ST_SETTLE ##1 state_reg == amfc_pkg::AMFC_ST_SETTLE;
    endsequence

    chk_standby_quiet: assert property (@(posedge clk) disable iff (rst)
        state_reg == amfc_pkg::AMFC_ST_STANDBY |-> !irq_enable && irq_clear && !data_valid)
        else $error("standby leaves interrupts or data live");
    chk_settle_no_data: assert property (@(posedge clk) disable iff (rst)
        state_reg == amfc_pkg::AMFC_ST_SETTLE |-> !data_valid && !fifo_store_en)
        else $error("data during settling");
    chk_instant_no_data: assert property (@(posedge clk) disable iff (rst)
        state_reg == amfc_pkg::AMFC_ST_INSTANT |-> !data_valid && !fifo_store_en)
        else $error("instant-on produced data");
    chk_impact_jump: assert property (@(posedge clk) disable iff (rst)
        state_reg == amfc_pkg::AMFC_ST_INSTANT && impact_detected &&
        req != amfc_pkg::AMFC_REQ_STANDBY |=> state_reg == amfc_pkg::AMFC_ST_SETTLE)
        else $error("impact ignored");
    chk_wake_no_fifo: assert property (@(posedge clk) disable iff (rst)
        state_reg == amfc_pkg::AMFC_ST_WON |-> !fifo_store_en && !irq_enable)
        else $error("wake mode stored or raised interrupt");
    chk_wake_activity: assert property (@(posedge clk) disable iff (rst)
        state_reg == amfc_pkg::AMFC_ST_WON && activity_detected && wake_auto_measure &&
        req != amfc_pkg::AMFC_REQ_STANDBY |=> state_reg == amfc_pkg::AMFC_ST_SETTLE)
        else $error("wake activity ignored");
    chk_bw_clamp: assert property (@(posedge clk) disable iff (rst)
        aa_bw_eff <= rate_eff && (bw_reg > rate_reg || aa_bw_eff == bw_reg))
        else $error("bandwidth clamp wrong");
    chk_rate_range: assert property (@(posedge clk) disable iff (rst)
        rate_eff <= `AMFC_RATE_MAX)
        else $error("rate code out of range");
    chk_settle_restart: assert property (@(posedge clk) disable iff (rst)
        s_enter_settle |-> !settle_done)
        else $error("settling not restarted");
endmodule // amfc_mode_ctrl
`default_nettype wire

// *** dv/amfc_host_model.sv ***
// Partner model: host side of settle choice, sample strobes and serial reads.
// Assumes one clock; every output changes just after a falling edge.
`default_nettype none
module amfc_host_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Commands from the bench
    input  wire logic       hpf_enable,
    input  wire logic       lpf_enable,
    input  wire logic       strobe_en,
    input  wire logic       burst_go,
    input  wire logic [7:0] burst_len,
    // Towards the block
    output logic            settle_time_select,
    output logic            sample_strobe,
    output logic            host_burst_active,
    output logic            fifo_read_byte,
    output logic            burst_done
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====================
    // Settle choice
    // Short settling corrupts filtered data, so it is picked only with both filters off
    assign settle_time_select = ~(hpf_enable | lpf_enable);
    // ====================
    // Strobes and burst reads
    logic [2:0] phase_reg;
    logic [8:0] left_reg;
    // One strobe in eight cycles; a burst of any length reads a byte every other cycle
    always @(negedge clk or posedge rst) begin
        if (rst) begin
            phase_reg         <= 3'h0;
            left_reg          <= 9'h000;
            sample_strobe     <= 1'b0;
            host_burst_active <= 1'b0;
            fifo_read_byte    <= 1'b0;
            burst_done        <= 1'b0;
        end else begin
            phase_reg         <= phase_reg + 3'h1;
            sample_strobe     <= strobe_en && (phase_reg == 3'h7);
            host_burst_active <= (left_reg != 9'h000);
            fifo_read_byte    <= (left_reg != 9'h000) && !left_reg[0];
            burst_done        <= (left_reg == 9'h001);
            if (left_reg != 9'h000) begin
                left_reg <= left_reg - 9'h001;
            end else if (burst_go) begin
                left_reg <= {burst_len, 1'b0};
            end
        end
    end
endmodule // amfc_host_model
`default_nettype wire

// *** dv/tb_amfc_mode_ctrl.sv ***
// Self-checking bench for the mode sequencer with the host model beside it.
// Assumes a compressed tick of TB_DIV cycles; only short settling is timed in full.
`default_nettype none
`include "amfc_cfg.svh"
module tb_amfc_mode_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    // ====================
    // Signals
    logic       clk = 1'b0, rst = 1'b1, strobe_en = 1'b1, burst_go = 1'b0;
    logic [1:0] mode_request = 2'h0, hpf_corner_select = 2'h0;
    logic [2:0] wake_timer_select = 3'h0, output_sample_rate = 3'h0, aa_bw_select = 3'h0;
    logic       hpf_enable = 1'b1, lpf_enable = 1'b1, low_noise_select = 1'b0;
    logic       impact_high_range = 1'b0, wake_auto_measure = 1'b0, loop_mode = 1'b0;
    logic       impact_detected = 1'b0, activity_detected = 1'b0;
    logic [7:0] burst_len = 8'h00;
    wire logic  settle_time_select, sample_strobe, host_burst_active, fifo_read_byte;
    wire logic  burst_done, mode_changed, sensing_on, data_valid, fifo_store_en;
    wire logic  irq_enable, irq_clear, fifo_advance, reg_addr_incr, hpf_on, lpf_on;
    wire logic  low_noise_on, impact_thresh_high, wake_downstream;
    wire logic [2:0] mode_state, rate_eff, aa_bw_eff;
    wire logic [1:0] hpf_corner_eff;
    int         mismatches = 0, tests_run = 0;
    localparam int TB_DIV = 100;  // Cycles per tick, so wake and settling fit a short run
    int         strobe_cnt = 0, valid_cnt = 0, store_cnt = 0, adv_cnt = 0, incr_cnt = 0;
    // ====================
    // Instances
    amfc_mode_ctrl #(.TICK_DIV(TB_DIV)) amfc_mode_ctrl_inst (
        .clk, .rst, .mode_request, .settle_time_select, .wake_timer_select,
        .output_sample_rate, .aa_bw_select, .hpf_corner_select, .hpf_enable, .lpf_enable,
        .low_noise_select, .impact_high_range, .wake_auto_measure, .loop_mode,
        .impact_detected, .activity_detected, .sample_strobe, .host_burst_active,
        .fifo_read_byte, .mode_state, .mode_changed, .sensing_on, .data_valid,
        .fifo_store_en, .irq_enable, .irq_clear, .fifo_advance, .reg_addr_incr,
        .rate_eff, .aa_bw_eff, .hpf_corner_eff, .hpf_on, .lpf_on, .low_noise_on,
        .impact_thresh_high, .wake_downstream
    );
    amfc_host_model amfc_host_model_inst (
        .clk, .rst, .hpf_enable, .lpf_enable, .strobe_en, .burst_go, .burst_len,
        .settle_time_select, .sample_strobe, .host_burst_active, .fifo_read_byte,
        .burst_done
    );
    // ====================
    // Clock and event counters
    always #50 clk = ~clk;
    // Counted on the falling edge, half a cycle from the block's launch edge; the host model launches on this edge
    always @(negedge clk) begin
        strobe_cnt <= strobe_cnt + int'(sample_strobe === 1'b1);
        valid_cnt  <= valid_cnt + int'(data_valid === 1'b1);
        store_cnt  <= store_cnt + int'(fifo_store_en === 1'b1);
        adv_cnt    <= adv_cnt + int'(fifo_advance === 1'b1);
        incr_cnt   <= incr_cnt + int'(reg_addr_incr === 1'b1);
    end
    // ====================
    // Helpers
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        if (mismatches == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic request(input logic [1:0] m);
        mode_request <= m;
        step(1);
    endtask
    // Bounded wait for a state; a hang ends the run
    task automatic wait_state(input logic [2:0] s, input int limit, output int n);
        for (n = 0; n < limit && mode_state !== s; n++) step(1);
        if (mode_state !== s) begin
            mismatches++;
            final_report();
        end
    endtask
    // Burst read of len bytes; a stuck burst ends the run
    task automatic do_burst(input logic [7:0] len);
        int a0, i0, n;
        a0 = adv_cnt;
        i0 = incr_cnt;
        burst_len <= len;
        burst_go  <= 1'b1;
        step(1);
        burst_go <= 1'b0;
        for (n = 0; n < 600 && burst_done !== 1'b1; n++) step(1);
        if (burst_done !== 1'b1) begin
            mismatches++;
            final_report();
        end
        step(2);
        check("fifo_advance count", 8'(adv_cnt - a0), len);
        check("reg_addr_incr cycles", 8'(incr_cnt - i0), 8'(2 * len));
    endtask
    // ====================
    // Scenarios
    task automatic test_reset();
        check("state", 8'(mode_state), 8'h00);
        check("sensing_on", 8'(sensing_on), 8'h00);
        check("irq_clear", 8'(irq_clear), 8'h01);
        check("irq_enable", 8'(irq_enable), 8'h00);
        check("rate_eff", 8'(rate_eff), 8'h00);
        check("aa_bw_eff", 8'(aa_bw_eff), 8'h00);
        check("wake_downstream", 8'(wake_downstream), 8'h00);
    endtask
    task automatic test_filters();
        for (int i = 0; i < 4; i++) begin
            hpf_corner_select <= 2'(i);
            hpf_enable        <= i[0];
            low_noise_select  <= i[1];
            impact_high_range <= ~i[0];
            step(1);
            check("hpf_corner_eff", 8'(hpf_corner_eff), 8'(i));
            check("hpf_on", 8'(hpf_on), 8'(i[0]));
            check("lpf_on", 8'(lpf_on), 8'h01);
            check("low_noise_on", 8'(low_noise_on), 8'(i[1]));
            check("impact_thresh_high", 8'(impact_thresh_high), 8'(!i[0]));
        end
    endtask
    // Every rate code, the out-of-range ones too, against bandwidth codes 0 to 4
    task automatic test_clamp();
        logic [2:0] er, eb;
        for (int r = 0; r < 8; r++) begin
            for (int b = 0; b < 5; b++) begin
                output_sample_rate <= 3'(r);
                aa_bw_select       <= 3'(b);
                step(2);
                er = (r > 4) ? 3'h4 : 3'(r);
                eb = (3'(b) > er) ? er : 3'(b);
                check("rate_eff", 8'(rate_eff), 8'(er));
                check("aa_bw_eff", 8'(aa_bw_eff), 8'(eb));
            end
        end
    endtask
    task automatic test_instant();
        int v0, s0;
        request(2'h2);
        check("state instant", 8'(mode_state), 8'h03);
        v0 = valid_cnt;
        s0 = store_cnt;
        step(40);
        check("data_valid instant", 8'(valid_cnt - v0), 8'h00);
        check("fifo_store_en instant", 8'(store_cnt - s0), 8'h00);
        do_burst(8'h05);
        impact_detected <= 1'b1;
        step(1);
        impact_detected <= 1'b0;
        check("state after impact", 8'(mode_state), 8'h01);
        check("mode_changed", 8'(mode_changed), 8'h01);
        step(1);
        check("mode_changed pulse", 8'(mode_changed), 8'h00);
        request(2'h0);
        check("state standby", 8'(mode_state), 8'h00);
        check("irq_clear standby", 8'(irq_clear), 8'h01);
        check("irq_enable standby", 8'(irq_enable), 8'h00);
    endtask
    task automatic test_wake();
        int v0, s0;
        request(2'h1);
        check("state wake", 8'(mode_state), 8'h04);
        v0 = valid_cnt;
        s0 = store_cnt;
        step(300);
        check("state asleep", 8'(mode_state), 8'h04);
        check("data_valid asleep", 8'(valid_cnt - v0), 8'h00);
        check("fifo_store_en wake", 8'(store_cnt - s0), 8'h00);
        check("irq_enable wake", 8'(irq_enable), 8'h00);
        do_burst(8'h03);
        request(2'h0);
        check("state standby", 8'(mode_state), 8'h00);
    endtask
    // Settling is timed against the tick; the tick phase at entry blurs it by one tick
    task automatic test_measure();
        int v0, s0, t0, n;
        int lo = `AMFC_SETTLE_SHORT_US / 1000 * TB_DIV - TB_DIV;
        int hi = lo + 3 * TB_DIV;
        hpf_enable         <= 1'b0;
        lpf_enable         <= 1'b0;
        output_sample_rate <= 3'h2;
        step(2);
        request(2'h3);
        check("state settle", 8'(mode_state), 8'h01);
        v0 = valid_cnt;
        wait_state(3'h2, hi, n);
        check("no data settling", 8'(valid_cnt == v0), 8'h01);
        check("settle long enough", 8'(n >= lo), 8'h01);
        check("aa_bw_eff", 8'(aa_bw_eff), 8'h02);
        v0 = valid_cnt;
        s0 = store_cnt;
        t0 = strobe_cnt;
        step(64);
        check("strobes", 8'(strobe_cnt - t0), 8'h08);
        check("data_valid", 8'(valid_cnt - v0), 8'h08);
        check("fifo_store_en", 8'(store_cnt - s0), 8'h08);
        check("irq_enable measure", 8'(irq_enable), 8'h01);
        output_sample_rate <= 3'h4;
        step(2);
        check("rate_eff held", 8'(rate_eff), 8'h02);
        loop_mode         <= 1'b1;
        activity_detected <= 1'b1;
        #10;
        check("irq_clear loop", 8'(irq_clear), 8'h01);
        step(1);
        activity_detected <= 1'b0;
        #10;
        check("irq_clear idle", 8'(irq_clear), 8'h00);
        step(1);
        loop_mode <= 1'b0;
        request(2'h0);
        check("state standby", 8'(mode_state), 8'h00);
        step(2);
        check("rate_eff standby", 8'(rate_eff), 8'h04);
    endtask
    // Wake-on phase, auto entry on activity, then the host re-arms wake by hand
    task automatic test_wake_on();
        int v0, s0, n;
        wake_auto_measure <= 1'b1;
        request(2'h1);
        wait_state(3'h5, 70 * TB_DIV, n);
        v0 = valid_cnt;
        s0 = store_cnt;
        step(16);
        check("data_valid wake", 8'(valid_cnt - v0), 8'h02);
        check("fifo_store_en won", 8'(store_cnt - s0), 8'h00);
        check("irq_enable won", 8'(irq_enable), 8'h00);
        activity_detected <= 1'b1;
        step(1);
        activity_detected <= 1'b0;
        check("state auto", 8'(mode_state), 8'h01);
        check("wake_downstream", 8'(wake_downstream), 8'h01);
        request(2'h0);
        request(2'h1);
        check("state rearmed", 8'(mode_state), 8'h04);
        check("wake_downstream off", 8'(wake_downstream), 8'h00);
        request(2'h0);
    endtask
    // ====================
    // Main sequence
    initial begin
        step(6);
        rst <= 1'b0;
        step(1);
        test_reset();
        test_filters();
        test_clamp();
        test_instant();
        test_wake();
        test_measure();
        test_wake_on();
        final_report();
    end
endmodule // tb_amfc_mode_ctrl
`default_nettype wire
